//--- umcir_pkg.sv
// package for the modem control, modem status and interrupt unit of one serial channel
// assumes a plain register port with byte-wide data in the low bits
package umcir_pkg;
	localparam int UMCIR_AW = 3;
	localparam logic [2:0] UMCIR_OFS_IER = 3'h1;
	localparam logic [2:0] UMCIR_OFS_IIR = 3'h2;
	localparam logic [2:0] UMCIR_OFS_MCR = 3'h4;
	localparam logic [2:0] UMCIR_OFS_MSR = 3'h6;
	localparam logic [2:0] UMCIR_OFS_AUX = 3'h7;
	localparam logic [7:0] UMCIR_RST_IER = 8'h00;
	localparam logic [7:0] UMCIR_RST_MCR = 8'h00;
	localparam logic [7:0] UMCIR_RST_AUX = 8'h00;
	localparam int UMCIR_MCR_DTR = 0;
	localparam int UMCIR_MCR_RTS = 1;
	localparam int UMCIR_MCR_RDY = 2;
	localparam int UMCIR_MCR_IRQ = 3;
	localparam int UMCIR_MCR_LOOP = 4;
	localparam int UMCIR_MCR_XANY = 5;
	localparam int UMCIR_MCR_TACC = 6;
	localparam int UMCIR_MCR_DIV4 = 7;
	localparam int UMCIR_AUX_ENH = 4;
	localparam int UMCIR_AUX_FEN = 0;
	localparam logic [5:0] UMCIR_ID_LSR = 6'h06;
	localparam logic [5:0] UMCIR_ID_RTO = 6'h0C;
	localparam logic [5:0] UMCIR_ID_RHR = 6'h04;
	localparam logic [5:0] UMCIR_ID_THR = 6'h02;
	localparam logic [5:0] UMCIR_ID_MDM = 6'h08;
	localparam logic [5:0] UMCIR_ID_XOF = 6'h10;
	localparam logic [5:0] UMCIR_ID_CRS = 6'h20;
	localparam logic [5:0] UMCIR_ID_NONE = 6'h01;
	typedef struct packed {
		logic cts_b;
		logic dsr_b;
		logic ri_b;
		logic cd_b;
	} umcir_modem_in_t;
	typedef struct packed {
		logic line_err;
		logic rx_timeout;
		logic rx_data;
		logic tx_below;
		logic xoff;
		logic cts_rise;
		logic rts_rise;
	} umcir_src_t;
endpackage

//--- umcir_top.sv
// modem control, modem status and interrupt identification for one serial channel
// assumes source levels come from datapath logic on clk_sys; modem pins are asynchronous
// Function
// R1: control bit0 drives dtr low when set; loopback feeds status bit5
// R2: control bit1 drives rts low when set unless auto rts owns the pin
// R3: control bit2 enables fifo ready status; loopback feeds status bit6
// R4: control bit3 enables interrupt pin, else high impedance; loopback feeds bit7
// R5: control bit4 selects loopback: tx to rx, low control bits to status
// R6: loopback maps control 0,1,2,3 to status 5,4,6,7
// R7: control bit5 enables resume on any character
// R8: control bit6 grants access to threshold and trigger registers
// R9: control bit7 selects divide by four; reset loads inverse of prescale pin
// R10: control bits 7..5 writable only while enhanced enable is set
// R11: status bits 0,1,3 flag cts, dsr, cd changes; cleared on status read
// R12: status bit2 flags ring rising edge; cleared on status read
// R13: status bits 7..4 show inverted modem inputs or control bits in loopback
// R14: enable bits gate receive, transmit, line, modem, xoff, rts, cts sources
// R15: enable bit4 enables sleep mode
// R16: enable bits 7..4 writable only while enhanced enable is set
// R17: re-enabling transmit interrupt below threshold raises a new one
// R18: interrupt output active whenever an enabled source interrupts
// R19: identify bit0 reads zero while any interrupt pending
// R20: identify bits 7,6 mirror fifo enable
// R21: code reports highest source; line error first, timeout and receive second
// R22: then transmit, modem, xoff or special, cts/rts inactive
// R23: threshold register writes need enhanced enable and control bit6
// R24: each source stays reported until its own clearing action
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module umcir_top
	import umcir_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [UMCIR_AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic iir_read,
	input wire logic tcr_wr_req,
	output logic tcr_wr_en,
	output logic tlr_access_en,
	input wire umcir_modem_in_t modem_pin,
	input wire logic prescale_sel_pin,
	input wire umcir_src_t src,
	input wire logic auto_rts_en,
	input wire logic auto_rts_b,
	input wire logic tx_serial,
	output logic rx_loop_serial,
	output logic loop_active,
	output logic tx_pin,
	output logic dtr_b,
	output logic rts_b,
	output logic irq_out,
	output logic irq_oe,
	output logic fifo_ready_en,
	output logic xon_any_en,
	output logic clk_div4,
	output logic sleep_en
);
	logic [7:0] mcr_ff;
	logic [7:0] ier_ff;
	logic [7:0] aux_ff;
	logic [3:0] delta_ff;
	logic [3:0] lvl_ff;
	logic lvl_valid_ff;
	umcir_modem_in_t meta_ff;
	umcir_modem_in_t pin_ff;
	logic clk_meta_ff;
	logic clk_sync_ff;
	logic [1:0] strap_cnt_ff;
	logic thr_flag_ff;
	logic tx_below_ff;
	logic xoff_flag_ff;
	logic cts_flag_ff;
	logic rts_flag_ff;
	logic [7:0] rdata_ff;
	logic [3:0] lvl_now;
	logic [7:0] msr_view;
	logic [5:0] id_code;
	logic wr_ier;
	logic wr_mcr;
	logic rd_msr;
	logic enh;
	logic loop;

	// merge a protected upper field: new bits only while enhanced enable is set
	function automatic logic [7:0] umcir_guard(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] prot, input logic en);
		umcir_guard = en ? new_v : ((old_v & prot) | (new_v & ~prot));
	endfunction

	assign enh = aux_ff[UMCIR_AUX_ENH];
	assign loop = mcr_ff[UMCIR_MCR_LOOP];
	assign wr_ier = reg_wr && (reg_addr == UMCIR_OFS_IER);
	assign wr_mcr = reg_wr && (reg_addr == UMCIR_OFS_MCR);
	assign rd_msr = reg_rd && (reg_addr == UMCIR_OFS_MSR);

	// modem pins pass two flops before any logic looks at them
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '1;
			pin_ff <= '1;
			clk_meta_ff <= 1'b0;
			clk_sync_ff <= 1'b0;
		end else begin
			meta_ff <= modem_pin;
			pin_ff <= meta_ff;
			clk_meta_ff <= prescale_sel_pin;
			clk_sync_ff <= clk_meta_ff;
		end
	end

	// active-high levels in order cd, ri, dsr, cts
	always_comb begin
		if (loop) begin
			lvl_now = {mcr_ff[UMCIR_MCR_IRQ], mcr_ff[UMCIR_MCR_RDY],
				mcr_ff[UMCIR_MCR_DTR], mcr_ff[UMCIR_MCR_RTS]}; // see R6
		end else begin
			lvl_now = {~pin_ff.cd_b, ~pin_ff.ri_b, ~pin_ff.dsr_b, ~pin_ff.cts_b}; // see R13
		end
	end

	// status view: change flags low, levels high (cts, dsr, ri, cd)
	assign msr_view = {lvl_now[3], lvl_now[2], lvl_now[1], lvl_now[0], delta_ff}; // see R13

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mcr_ff <= UMCIR_RST_MCR;
			strap_cnt_ff <= 2'h3;
		end else begin
			if (wr_mcr) begin
				mcr_ff <= umcir_guard(mcr_ff, reg_wdata, 8'hE0, enh); // see R10
			end
			// the synchroniser is held in reset, so the strap is valid only on the third edge
			if (strap_cnt_ff != 2'h0) begin
				strap_cnt_ff <= strap_cnt_ff - 2'h1;
			end
			if (strap_cnt_ff == 2'h1) begin
				mcr_ff[UMCIR_MCR_DIV4] <= ~clk_sync_ff; // see R9
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ier_ff <= UMCIR_RST_IER;
		end else if (wr_ier) begin
			ier_ff <= umcir_guard(ier_ff, reg_wdata, 8'hF0, enh); // see R16
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			aux_ff <= UMCIR_RST_AUX;
		end else if (reg_wr && (reg_addr == UMCIR_OFS_AUX)) begin
			aux_ff <= reg_wdata & 8'h11;
		end
	end

	// change detection; the first sample after reset only primes the copy
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lvl_ff <= 4'h0;
			lvl_valid_ff <= 1'b0;
			delta_ff <= 4'h0;
		end else begin
			lvl_ff <= lvl_now;
			lvl_valid_ff <= 1'b1;
			// a change in the read cycle survives: set wins over clear
			delta_ff <= (rd_msr ? 4'h0 : delta_ff) | (lvl_valid_ff ?
				{lvl_now[3] ^ lvl_ff[3], lvl_now[2] & ~lvl_ff[2],
				lvl_now[1] ^ lvl_ff[1], lvl_now[0] ^ lvl_ff[0]} : 4'h0); // see R11, R12
		end
	end

	// transmit interrupt: set on entering below-threshold or on re-enable, cleared by
	// identify read while it is reported, or when the level rises above threshold
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			thr_flag_ff <= 1'b0;
			tx_below_ff <= 1'b0;
		end else begin
			tx_below_ff <= src.tx_below;
			if ((src.tx_below && !tx_below_ff) ||
				(src.tx_below && wr_ier && reg_wdata[1] && !ier_ff[1])) begin
				thr_flag_ff <= 1'b1; // see R17
			end else if (!src.tx_below || (iir_read && id_code == UMCIR_ID_THR)) begin
				thr_flag_ff <= 1'b0; // see R24
			end
		end
	end

	// xoff and cts/rts events latch until an identify read reports their code
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			xoff_flag_ff <= 1'b0;
			cts_flag_ff <= 1'b0;
			rts_flag_ff <= 1'b0;
		end else begin
			xoff_flag_ff <= src.xoff | (xoff_flag_ff & ~(iir_read && id_code == UMCIR_ID_XOF));
			cts_flag_ff <= src.cts_rise | (cts_flag_ff & ~(iir_read && id_code == UMCIR_ID_CRS));
			rts_flag_ff <= src.rts_rise | (rts_flag_ff & ~(iir_read && id_code == UMCIR_ID_CRS));
		end
	end

	// priority encoder, highest first
	always_comb begin
		if (ier_ff[2] && src.line_err) begin
			id_code = UMCIR_ID_LSR; // see R21
		end else if (ier_ff[0] && src.rx_timeout) begin
			id_code = UMCIR_ID_RTO; // see R21
		end else if (ier_ff[0] && src.rx_data) begin
			id_code = UMCIR_ID_RHR; // see R21
		end else if (ier_ff[1] && thr_flag_ff) begin
			id_code = UMCIR_ID_THR; // see R22
		end else if (ier_ff[3] && (delta_ff != 4'h0)) begin
			id_code = UMCIR_ID_MDM; // see R22, R24
		end else if (ier_ff[5] && xoff_flag_ff) begin
			id_code = UMCIR_ID_XOF; // see R22
		end else if ((ier_ff[7] && cts_flag_ff) || (ier_ff[6] && rts_flag_ff)) begin
			id_code = UMCIR_ID_CRS; // see R14, R22
		end else begin
			id_code = UMCIR_ID_NONE; // see R19
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				UMCIR_OFS_IER: rdata_ff <= ier_ff;
				UMCIR_OFS_IIR: rdata_ff <= {{2{aux_ff[UMCIR_AUX_FEN]}}, id_code}; // see R19, R20
				UMCIR_OFS_MCR: rdata_ff <= mcr_ff;
				UMCIR_OFS_MSR: rdata_ff <= msr_view;
				UMCIR_OFS_AUX: rdata_ff <= aux_ff;
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end
	assign reg_rdata = rdata_ff;

	// pins: in loopback the modem outputs rest inactive and tx idles high
	assign dtr_b = loop ? 1'b1 : ~mcr_ff[UMCIR_MCR_DTR]; // see R1
	assign rts_b = loop ? 1'b1 : (auto_rts_en ? auto_rts_b : ~mcr_ff[UMCIR_MCR_RTS]); // see R2
	assign tx_pin = loop ? 1'b1 : tx_serial; // see R5
	assign rx_loop_serial = tx_serial; // see R5
	assign loop_active = loop; // see R5
	assign fifo_ready_en = mcr_ff[UMCIR_MCR_RDY] & ~loop; // see R3
	// pin released in loopback since bit3 then feeds status instead
	assign irq_oe = mcr_ff[UMCIR_MCR_IRQ] & ~loop; // see R4
	assign irq_out = (id_code != UMCIR_ID_NONE); // see R18
	assign xon_any_en = mcr_ff[UMCIR_MCR_XANY]; // see R7
	assign tlr_access_en = enh & mcr_ff[UMCIR_MCR_TACC]; // see R8
	assign tcr_wr_en = tcr_wr_req & enh & mcr_ff[UMCIR_MCR_TACC]; // see R23
	assign clk_div4 = mcr_ff[UMCIR_MCR_DIV4]; // see R9
	assign sleep_en = ier_ff[4]; // see R15
endmodule

//--- umcir_top_asserts.sv
// checker for the modem control and interrupt unit ports
// assumes one clock domain and only the top module's ports
`timescale 1ns/1ps
module umcir_top_asserts
	import umcir_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [UMCIR_AW-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic tcr_wr_req,
	input wire logic tcr_wr_en,
	input wire logic tlr_access_en,
	input wire logic auto_rts_en,
	input wire logic auto_rts_b,
	input wire logic tx_serial,
	input wire logic rx_loop_serial,
	input wire logic loop_active,
	input wire logic tx_pin,
	input wire logic dtr_b,
	input wire logic rts_b,
	input wire logic irq_oe,
	input wire logic fifo_ready_en,
	input wire logic sleep_en
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	dtr_loop_a: assert property (loop_active |-> dtr_b)
		else $error("dtr active in loopback");
	auto_rts_a: assert property (!loop_active && auto_rts_en |-> rts_b == auto_rts_b)
		else $error("rts not from flow engine");
	rdy_loop_a: assert property (loop_active |-> !fifo_ready_en)
		else $error("fifo ready on in loopback");
	irq_loop_a: assert property (loop_active |-> !irq_oe)
		else $error("irq pin driven in loopback");
	tx_route_a: assert property (rx_loop_serial == tx_serial && tx_pin == (loop_active || tx_serial))
		else $error("serial loop routing wrong");
	tcr_gate_a: assert property (tcr_wr_en == (tcr_wr_req && tlr_access_en))
		else $error("threshold write gate wrong");
	sleep_wr_a: assert property ($rose(sleep_en) |-> $past(reg_wr) && $past(reg_addr) == UMCIR_OFS_IER)
		else $error("sleep enable rose without write");
	access_wr_a: assert property ($changed(tlr_access_en) |-> $past(reg_wr))
		else $error("access grant moved without write");
	cover property (loop_active);
	cover property (tcr_wr_en);
	cover property ($rose(sleep_en));
endmodule
bind umcir_top umcir_top_asserts u_umcir_top_asserts (.*);

//--- umcir_modem.sv
// modem-side partner driving the active-low handshake pins
// assumes the bench commands the levels; idle level is inactive high
`timescale 1ns/1ps
module umcir_modem
	import umcir_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [3:0] lvl,
	output umcir_modem_in_t modem_pin
);
	// pins move just after an edge, never at the sampling instant
	always_ff @(posedge clk_sys) begin
		modem_pin <= umcir_modem_in_t'(lvl);
	end
endmodule

//--- umcir_top_tb.sv
// self-checking bench for the modem control and interrupt unit
// assumes the partner model owns the modem pins
`timescale 1ns/1ps
module umcir_top_tb;
	import umcir_pkg::*;
	logic clk_sys, rst_b, reg_wr, reg_rd, iir_read, tcr_wr_req, tcr_wr_en, tlr_access_en;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, got;
	logic [3:0] lvl;
	umcir_modem_in_t modem_pin;
	umcir_src_t src;
	logic prescale_sel_pin, auto_rts_en, auto_rts_b, tx_serial, rx_loop_serial, loop_active;
	logic tx_pin, dtr_b, rts_b, irq_out, irq_oe, fifo_ready_en, xon_any_en, clk_div4, sleep_en;
	int num_errors, n_tests;
	umcir_top u_umcir_top (.*);
	umcir_modem u_umcir_modem (.clk_sys(clk_sys), .lvl(lvl), .modem_pin(modem_pin));
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		iir_read <= (a == UMCIR_OFS_IIR);
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		iir_read <= 1'b0;
		#1 got = reg_rdata;
	endtask
	task automatic t_reset;
		rd(UMCIR_OFS_MCR);
		chk("mcr reset", 8'h00, got);
		chk("pins reset", 8'h03, {6'h00, dtr_b, rts_b});
		$display("reset test done");
	endtask
	task automatic t_guard;
		wr(UMCIR_OFS_MCR, 8'hE0);
		wr(UMCIR_OFS_IER, 8'hF0);
		rd(UMCIR_OFS_IER);
		chk("ier locked", 8'h00, got);
		wr(UMCIR_OFS_AUX, 8'h10);
		wr(UMCIR_OFS_MCR, 8'hE0);
		wr(UMCIR_OFS_IER, 8'h10);
		tcr_wr_req <= 1'b1;
		#1 chk("enh outs", 8'h1F, {3'h0, xon_any_en, tlr_access_en, clk_div4, sleep_en, tcr_wr_en});
		@(posedge clk_sys);
		tcr_wr_req <= 1'b0;
		wr(UMCIR_OFS_AUX, 8'h00);
		wr(UMCIR_OFS_MCR, 8'h00);
		rd(UMCIR_OFS_MCR);
		chk("mcr locked", 8'hE0, got);
		$display("guard test done");
	endtask
	task automatic t_modem;
		wr(UMCIR_OFS_MCR, 8'h07);
		#1 chk("dtr rts on", 8'h04, {5'h00, fifo_ready_en, dtr_b, rts_b});
		auto_rts_en <= 1'b1;
		auto_rts_b <= 1'b1;
		@(posedge clk_sys);
		#1 chk("auto rts", 8'h01, {7'h00, rts_b});
		@(posedge clk_sys);
		auto_rts_en <= 1'b0;
		auto_rts_b <= 1'b0;
		rd(UMCIR_OFS_MSR);
		lvl <= 4'h2;
		repeat (5) @(posedge clk_sys);
		rd(UMCIR_OFS_MSR);
		chk("msr change", 8'hBB, got);
		rd(UMCIR_OFS_MSR);
		chk("msr cleared", 8'hB0, got);
		lvl <= 4'hF;
		repeat (5) @(posedge clk_sys);
		rd(UMCIR_OFS_MSR);
		$display("modem test done");
	endtask
	task automatic t_loop;
		wr(UMCIR_OFS_MCR, 8'h1F);
		tx_serial <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(UMCIR_OFS_MSR);
		chk("loop msr", 8'hFF, got);
		chk("loop pins", 8'h1E, {1'b0, fifo_ready_en, irq_oe, dtr_b, rts_b, loop_active, tx_pin, rx_loop_serial});
		tx_serial <= 1'b1;
		wr(UMCIR_OFS_MCR, 8'h00);
		repeat (3) @(posedge clk_sys);
		rd(UMCIR_OFS_MSR);
		$display("loop test done");
	endtask
	task automatic t_irq;
		logic [7:0] ien [3] = '{8'h20, 8'h80, 8'h40};
		logic [6:0] sv [3] = '{7'h04, 7'h02, 7'h01};
		logic [7:0] id [3] = '{8'hD0, 8'hE0, 8'hE0};
		wr(UMCIR_OFS_AUX, 8'h11);
		wr(UMCIR_OFS_MCR, 8'h08);
		wr(UMCIR_OFS_IER, 8'h05);
		src <= umcir_src_t'(7'h50);
		rd(UMCIR_OFS_IIR);
		chk("line id", 8'hC6, got);
		chk("irq pin", 8'h03, {6'h00, irq_out, irq_oe});
		src <= umcir_src_t'(7'h10);
		rd(UMCIR_OFS_IIR);
		chk("rx id", 8'hC4, got);
		src <= umcir_src_t'(7'h08);
		rd(UMCIR_OFS_IIR);
		chk("thr masked", 8'hC1, got);
		wr(UMCIR_OFS_IER, 8'h07);
		rd(UMCIR_OFS_IIR);
		chk("thr id", 8'hC2, got);
		rd(UMCIR_OFS_IIR);
		chk("thr cleared", 8'hC1, got);
		wr(UMCIR_OFS_IER, 8'h05);
		wr(UMCIR_OFS_IER, 8'h07);
		rd(UMCIR_OFS_IIR);
		chk("thr reenable", 8'hC2, got);
		rd(UMCIR_OFS_IIR);
		chk("thr reclear", 8'hC1, got);
		wr(UMCIR_OFS_IER, 8'h08);
		lvl <= 4'h7;
		repeat (5) @(posedge clk_sys);
		rd(UMCIR_OFS_IIR);
		chk("modem id", 8'hC8, got);
		rd(UMCIR_OFS_MSR);
		rd(UMCIR_OFS_IIR);
		chk("modem cleared", 8'hC1, got);
		for (int i = 0; i < 3; i++) begin
			wr(UMCIR_OFS_IER, ien[i]);
			src <= umcir_src_t'(sv[i]);
			@(posedge clk_sys);
			src <= umcir_src_t'(7'h00);
			rd(UMCIR_OFS_IIR);
			chk("pulse id", id[i], got);
			rd(UMCIR_OFS_IIR);
			chk("pulse cleared", 8'hC1, got);
		end
		$display("interrupt test done");
	endtask
	task automatic t_strap;
		prescale_sel_pin <= 1'b0;
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(UMCIR_OFS_MCR);
		chk("mcr strap", 8'h80, got);
		$display("strap test done");
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		rst_b = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, iir_read, tcr_wr_req} = '0;
		lvl = 4'hF;
		src = umcir_src_t'(7'h00);
		prescale_sel_pin = 1'b1;
		{auto_rts_en, auto_rts_b, tx_serial} = 3'h1;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset;
		t_guard;
		t_modem;
		t_loop;
		t_irq;
		t_strap;
		conclude;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		conclude;
	end
endmodule
